// [core/idmp_pkg.sv]
package idmp_pkg;

  // I/O offsets of the registers served by this block
  localparam logic [7:0] IDMP_OFS_MODE      = 8'h0b;
  localparam logic [7:0] IDMP_OFS_PAGE_CH2  = 8'h81;
  localparam logic [7:0] IDMP_OFS_PAGE_CH3  = 8'h82;
  localparam logic [7:0] IDMP_OFS_PAGE_CH1  = 8'h83;
  localparam logic [7:0] IDMP_OFS_PAGE_CH0  = 8'h87;
  localparam logic [7:0] IDMP_OFS_BPTR_CLR  = 8'hd8;
  localparam logic [7:0] IDMP_OFS_MCLR      = 8'hda;
  localparam logic [7:0] IDMP_OFS_UNMASK    = 8'hdc;
  localparam logic [7:0] IDMP_OFS_MASK_ALL  = 8'hde;

  // Mode register field positions
  localparam int unsigned IDMP_MODE_XMODE_HI = 7;
  localparam int unsigned IDMP_MODE_XMODE_LO = 6;
  localparam int unsigned IDMP_MODE_DEC_BIT  = 5;
  localparam int unsigned IDMP_MODE_AUTO_BIT = 4;
  localparam int unsigned IDMP_MODE_TYPE_HI  = 3;
  localparam int unsigned IDMP_MODE_TYPE_LO  = 2;

  // Reset values and fixed readback values
  localparam logic [5:0] IDMP_MODE_RST  = 6'h00;
  localparam logic [7:0] IDMP_PAGE_RST  = 8'h00;
  localparam logic [3:0] IDMP_MASK_RST  = 4'h0;
  localparam logic [1:0] IDMP_SEL_READ  = 2'h3;
  localparam logic [3:0] IDMP_MASK_RSVD = 4'h0;

  // Transfer modes
  localparam logic [1:0] IDMP_XM_DEMAND  = 2'h0;
  localparam logic [1:0] IDMP_XM_SINGLE  = 2'h1;
  localparam logic [1:0] IDMP_XM_BLOCK   = 2'h2;
  localparam logic [1:0] IDMP_XM_CASCADE = 2'h3;

  // Transfer types; 11 is undefined, stored and output as written (the host model sends verify)
  localparam logic [1:0] IDMP_TT_VERIFY = 2'h0;
  localparam logic [1:0] IDMP_TT_WRITE  = 2'h1;
  localparam logic [1:0] IDMP_TT_READ   = 2'h2;

  // Stored mode of one channel (selector bits are not stored)
  typedef struct packed {
    logic [1:0] xmode;
    logic       dec;
    logic       autoinit;
    logic [1:0] xtype;
  } idmp_mode_s;

  // One I/O access from the host
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } idmp_io_s;

  // Transfer progress strobes for the byte-wide controller
  typedef struct packed {
    logic       start;
    logic       step;
    logic [1:0] chan;
  } idmp_xfer_s;

endpackage

// [core/idmp_regfile.sv]
`timescale 1ns/1ps
// Small register array for the four channel modes, registered read port
module idmp_regfile
  import idmp_pkg::*;
#(
  parameter int unsigned DEPTH = 4
)
(
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire logic                     ce,
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire idmp_mode_s               wdata,
  input  wire logic [$clog2(DEPTH)-1:0] raddr,
  output idmp_mode_s                    rdata,
  output idmp_mode_s [DEPTH-1:0]        all
);

  // Elaboration check: a single word leaves no select bits for the walk
  if (DEPTH < 2)
  begin : g_bad_depth
    $error("idmp_regfile: DEPTH must be at least 2");
  end

  typedef struct packed {
    idmp_mode_s [DEPTH-1:0] mem;
    idmp_mode_s             rd;
  } idmp_rf_s;

  idmp_rf_s st_r;
  idmp_rf_s st_nxt;

  // Write port and registered read
  always_comb
  begin
    st_nxt = st_r;
    if (we)
      st_nxt.mem[waddr] = wdata;
    st_nxt.rd = st_r.mem[raddr];
  end

  // Demand mode after reset
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      st_r <= '0;
    else if (ce)
      st_r <= st_nxt;
  end

  assign rdata = st_r.rd;
  assign all   = st_r.mem;

endmodule

// [core/idmp_chan.sv]
`timescale 1ns/1ps
// Address and count engine of one byte-wide channel
module idmp_chan
  import idmp_pkg::*;
#(
  parameter int unsigned AW = 16
)
(
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          ce,
  input  wire logic          load,
  input  wire logic [AW-1:0] base_addr,
  input  wire logic [AW-1:0] base_count,
  input  wire logic          step,
  input  wire logic          dec,
  input  wire logic          autoinit,
  output logic [AW-1:0]      cur_addr,
  output logic               tc
);

  // Elaboration check: narrower counters cannot hold a byte offset
  if (AW < 8)
  begin : g_bad_aw
    $error("idmp_chan: AW must be at least 8");
  end

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [AW-1:0] cnt;
    logic          tc;
  } idmp_ch_s;

  idmp_ch_s st_r;
  idmp_ch_s st_nxt;
  logic     at_end;

  assign at_end = (st_r.cnt == '0);

  // One transfer per step; a step taken at count zero wraps or reloads and gives terminal count
  always_comb
  begin
    st_nxt    = st_r;
    st_nxt.tc = 1'b0;
    if (load)
    begin
      st_nxt.addr = base_addr;
      st_nxt.cnt  = base_count;
    end
    else if (step)
    begin
      st_nxt.tc = at_end;
      if (at_end && autoinit)
      begin
        st_nxt.addr = base_addr;
        st_nxt.cnt  = base_count;
      end
      else
      begin
        st_nxt.addr = dec ? st_r.addr - 1'b1 : st_r.addr + 1'b1;
        st_nxt.cnt  = st_r.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      st_r <= '0;
    else if (ce)
      st_r <= st_nxt;
  end

  assign cur_addr = st_r.addr;
  assign tc       = st_r.tc;

  a_chan_dir: assert property (@(posedge clk) disable iff (reset)
    ce && step && !load && !(at_end && autoinit) |=>
      cur_addr == ($past(dec) ? $past(cur_addr) - 1'b1 : $past(cur_addr) + 1'b1))
    else $error("address did not move in programmed direction");

  a_chan_reload: assert property (@(posedge clk) disable iff (reset)
    ce && step && !load && at_end && autoinit |=> cur_addr == $past(base_addr) && tc)
    else $error("autoinit did not reload at terminal count");

endmodule

// [core/idmp_top.sv]
`timescale 1ns/1ps
// How it works
// - Mode bits 7:6 pick demand, single, block or cascade; reset gives demand.
// - Mode bit 5 clear increments the address, set decrements it.
// - With autoinit set, terminal count reloads address and count from base.
// - An autoinitialised channel keeps its mask bit at terminal count.
// - Transfer type 00 verify, 01 write, 10 read; 11 must not be used.
// - A mode write lands only in the channel named by data bits 1:0.
// - Mode reads walk channels 0 to 3; a clear restarts at channel 0.
// - Mode readback shows ones in the channel selector bits.
// - Any write to the byte pointer clear address zeroes the byte pointer.
// - Any write to the master clear address clears the word controller.
// - Any write to the unmask address clears all word controller mask bits.
// - The all-bits mask address reads and writes the whole mask register.
// - Mask bits 3..0 cover channels 7..4; upper bits read zero.
// - Processor reset clears the whole word controller mask.
// - Page registers for channels 2,3,1,0 sit at 81h,82h,83h,87h.
// - Every page register resets to all zeros.
// - Master clear also clears the terminal count status bits.
module idmp_top
  import idmp_pkg::*;
#(
  parameter int unsigned NCH = 4,
  parameter int unsigned AW  = 16
)
(
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             ce,
  input  wire idmp_io_s         io,
  output logic [7:0]            rdata,
  output logic                  rvalid,
  input  wire logic             mode_cnt_clr,
  input  wire logic             wide_access,
  input  wire logic [NCH*AW-1:0] base_addr,
  input  wire logic [NCH*AW-1:0] base_count,
  input  wire idmp_xfer_s       xfer,
  input  wire logic [3:0]       wide_tc_evt,
  output logic [23:0]           mem_addr,
  output logic [1:0]            xfer_mode,
  output logic [1:0]            xfer_type,
  output logic [NCH-1:0]        byte_auto_mask_set,
  output logic [3:0]            wide_mask,
  output logic [3:0]            wide_tc_status,
  output logic                  byte_ptr,
  output logic                  wide_mclr
);

  // Elaboration checks: the page decode and the 24-bit address assume four 16-bit channels
  if (NCH != 4)
  begin : g_bad_nch
    $error("idmp_top: NCH must be 4");
  end
  if (AW != 16)
  begin : g_bad_aw
    $error("idmp_top: AW must be 16");
  end

  typedef struct packed {
    logic [NCH-1:0][7:0] page;
    logic [3:0]          mask;
    logic [3:0]          tcst;
    logic [1:0]          rdcnt;
    logic                bptr;
    logic                mclr;
    logic [7:0]          rdata;
    logic                rvalid;
    logic                rd_mode;
    logic [1:0]          act_ch;
    logic [23:0]         maddr;
  } idmp_st_s;

  idmp_st_s          st_r;
  idmp_st_s          st_nxt;
  idmp_mode_s        mode_wdata;
  idmp_mode_s        mode_rdata;
  idmp_mode_s [NCH-1:0] modes;
  logic [NCH-1:0][AW-1:0] cur_addr;
  logic [NCH-1:0]    tc;
  logic              wr_mode;
  logic              rd_mode;

  // Page register index for a page offset, or none
  function automatic logic [2:0] page_sel(input logic [7:0] a);
    unique case (a)
      IDMP_OFS_PAGE_CH0: page_sel = 3'h4;
      IDMP_OFS_PAGE_CH1: page_sel = 3'h5;
      IDMP_OFS_PAGE_CH2: page_sel = 3'h6;
      IDMP_OFS_PAGE_CH3: page_sel = 3'h7;
      default:           page_sel = 3'h0;
    endcase
  endfunction

  // Packed channel mode from written byte; selector bits are dropped
  function automatic idmp_mode_s mode_of(input logic [7:0] d);
    mode_of.xmode    = d[IDMP_MODE_XMODE_HI:IDMP_MODE_XMODE_LO];
    mode_of.dec      = d[IDMP_MODE_DEC_BIT];
    mode_of.autoinit = d[IDMP_MODE_AUTO_BIT];
    mode_of.xtype    = d[IDMP_MODE_TYPE_HI:IDMP_MODE_TYPE_LO];
  endfunction

  assign wr_mode    = io.wr && io.addr == IDMP_OFS_MODE;
  assign rd_mode    = io.rd && io.addr == IDMP_OFS_MODE;
  assign mode_wdata = mode_of(io.wdata);

  idmp_regfile #(.DEPTH(NCH)) u_modes (
    .clk   (clk),
    .reset (reset),
    .ce    (ce),
    .we    (wr_mode),
    .waddr (io.wdata[1:0]),
    .wdata (mode_wdata),
    .raddr (st_r.rdcnt),
    .rdata (mode_rdata),
    .all   (modes)
  );

  // One address engine per byte-wide channel
  for (genvar g = 0; g < NCH; g++)
  begin : g_ch
    logic sel;
    assign sel = xfer.chan == 2'(g);
    idmp_chan #(.AW(AW)) u_ch (
      .clk        (clk),
      .reset      (reset),
      .ce         (ce),
      .load       (xfer.start && sel),
      .base_addr  (base_addr[g*AW +: AW]),
      .base_count (base_count[g*AW +: AW]),
      .step       (xfer.step && sel),
      .dec        (modes[g].dec),
      .autoinit   (modes[g].autoinit),
      .cur_addr   (cur_addr[g]),
      .tc         (tc[g])
    );
    assign byte_auto_mask_set[g] = tc[g] && !modes[g].autoinit;
    a_no_automask: assert property (@(posedge clk) disable iff (reset)
      tc[g] && modes[g].autoinit |-> !byte_auto_mask_set[g])
      else $error("autoinit channel masked itself");
  end

  // Register accesses and special commands
  always_comb
  begin
    logic [2:0] ps;
    ps            = page_sel(io.addr);
    st_nxt        = st_r;
    st_nxt.mclr   = 1'b0;
    st_nxt.rvalid = io.rd;
    st_nxt.rd_mode = rd_mode;
    st_nxt.act_ch = xfer.chan;
    st_nxt.rdata  = 8'h00;
    // Terminal count events are sticky; a clear in the same cycle loses
    st_nxt.tcst   = st_r.tcst | wide_tc_evt;
    if (wide_access)
      st_nxt.bptr = ~st_r.bptr;
    if (rd_mode)
      st_nxt.rdcnt = st_r.rdcnt + 2'h1;
    if (mode_cnt_clr)
      st_nxt.rdcnt = 2'h0;
    if (io.wr)
    begin
      unique case (io.addr)
        IDMP_OFS_BPTR_CLR: st_nxt.bptr = 1'b0;
        IDMP_OFS_MCLR:
        begin
          st_nxt.mclr = 1'b1;
          st_nxt.bptr = 1'b0;
          st_nxt.mask = IDMP_MASK_RST;
          st_nxt.tcst = wide_tc_evt;
        end
        IDMP_OFS_UNMASK:   st_nxt.mask = IDMP_MASK_RST;
        IDMP_OFS_MASK_ALL: st_nxt.mask = io.wdata[3:0];
        default:
        begin
          if (ps[2])
            st_nxt.page[ps[1:0]] = io.wdata;
        end
      endcase
    end
    if (io.rd)
    begin
      if (io.addr == IDMP_OFS_MASK_ALL)
        st_nxt.rdata = {IDMP_MASK_RSVD, st_r.mask};
      else if (ps[2])
        st_nxt.rdata = st_r.page[ps[1:0]];
    end
    st_nxt.maddr = {st_r.page[xfer.chan], cur_addr[xfer.chan]};
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      st_r <= '0;
    else if (ce)
      st_r <= st_nxt;
  end

  assign rdata = st_r.rd_mode ? {mode_rdata, IDMP_SEL_READ} : st_r.rdata;
  assign rvalid = st_r.rvalid;

  assign xfer_mode      = modes[st_r.act_ch].xmode;
  assign xfer_type      = modes[st_r.act_ch].xtype;
  assign mem_addr       = st_r.maddr;
  assign wide_mask      = st_r.mask;
  assign wide_tc_status = st_r.tcst;
  assign byte_ptr       = st_r.bptr;
  assign wide_mclr      = st_r.mclr;

  a_mode_readback: assert property (@(posedge clk) disable iff (reset)
    ce && rd_mode |=> rdata[1:0] == IDMP_SEL_READ && rvalid)
    else $error("mode readback selector not ones");

  a_mode_reset: assert property (@(posedge clk)
    $fell(reset) |-> modes[0].xmode == IDMP_XM_DEMAND)
    else $error("mode not demand after reset");

  a_walk_clear: assert property (@(posedge clk) disable iff (reset)
    ce && mode_cnt_clr |=> st_r.rdcnt == 2'h0)
    else $error("read walk did not restart");

  a_walk_step: assert property (@(posedge clk) disable iff (reset)
    ce && rd_mode && !mode_cnt_clr |=> st_r.rdcnt == $past(st_r.rdcnt) + 2'h1)
    else $error("read walk did not advance");

  a_mode_steer: assert property (@(posedge clk) disable iff (reset)
    ce && wr_mode |=> modes[$past(io.wdata[1:0])] == $past(mode_wdata))
    else $error("mode write missed its channel");

  a_bptr_clear: assert property (@(posedge clk) disable iff (reset)
    ce && io.wr && io.addr == IDMP_OFS_BPTR_CLR |=> !byte_ptr)
    else $error("byte pointer not cleared");

  a_mclr_all: assert property (@(posedge clk) disable iff (reset)
    ce && io.wr && io.addr == IDMP_OFS_MCLR |=> wide_mclr && wide_mask == 4'h0 && !byte_ptr)
    else $error("master clear incomplete");

  a_mclr_tc: assert property (@(posedge clk) disable iff (reset)
    ce && io.wr && io.addr == IDMP_OFS_MCLR |=> wide_tc_status == $past(wide_tc_evt))
    else $error("tc status survived master clear");

  a_unmask_all: assert property (@(posedge clk) disable iff (reset)
    ce && io.wr && io.addr == IDMP_OFS_UNMASK |=> wide_mask == 4'h0)
    else $error("unmask did not clear mask");

  // Host leaves one idle cycle between accesses, so the readback comes two edges after the write
  a_mask_rw: assert property (@(posedge clk) disable iff (reset)
    ce && io.wr && io.addr == IDMP_OFS_MASK_ALL ##1 ce && !io.wr ##1 ce && io.rd && io.addr == IDMP_OFS_MASK_ALL
      |=> rdata == {IDMP_MASK_RSVD, $past(io.wdata[3:0], 3)})
    else $error("mask readback mismatch");

  a_mask_reset: assert property (@(posedge clk)
    $fell(reset) |-> wide_mask == 4'h0 && st_r.page == '0)
    else $error("mask or page not clear after reset");

  a_page_addr: assert property (@(posedge clk) disable iff (reset)
    ce |=> mem_addr[23:16] == $past(st_r.page[xfer.chan]))
    else $error("page not on upper address");

  a_mode_others: assert property (@(posedge clk) disable iff (reset)
    ce && wr_mode |=> modes[$past(io.wdata[1:0]) ^ 2'h1] == $past(modes[io.wdata[1:0] ^ 2'h1]))
    else $error("mode write touched another channel");

  a_walk_hold: assert property (@(posedge clk) disable iff (reset)
    ce && !rd_mode && !mode_cnt_clr |=> st_r.rdcnt == $past(st_r.rdcnt))
    else $error("read walk moved without a read");

  a_page_write: assert property (@(posedge clk) disable iff (reset)
    ce && io.wr && io.addr == IDMP_OFS_PAGE_CH2 |=> st_r.page[2] == $past(io.wdata))
    else $error("channel two page write lost");

  a_mask_upper: assert property (@(posedge clk) disable iff (reset)
    ce && io.rd && io.addr == IDMP_OFS_MASK_ALL |=> rvalid && rdata == {IDMP_MASK_RSVD, $past(wide_mask)})
    else $error("mask read upper bits not zero");

  a_bptr_toggle: assert property (@(posedge clk) disable iff (reset)
    ce && wide_access && !(io.wr && (io.addr == IDMP_OFS_BPTR_CLR || io.addr == IDMP_OFS_MCLR))
      |=> byte_ptr != $past(byte_ptr))
    else $error("byte pointer did not toggle");

  a_mclr_pulse: assert property (@(posedge clk) disable iff (reset)
    ce && !(io.wr && io.addr == IDMP_OFS_MCLR) |=> !wide_mclr)
    else $error("master clear pulse without command");

endmodule

// [dv/idmp_host_model.sv]
`timescale 1ns/1ps
// Host side: one-cycle I/O strobes launched at the falling edge
module idmp_host_model
  import idmp_pkg::*;
(
  input  wire logic clk,
  output idmp_io_s  io
);
  initial io = '0;

  // Idle bus shows inverted values so a stale copy never passes
  task automatic access(input logic rd, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    io = '{rd: rd, wr: !rd, addr: a, wdata: d};
    @(negedge clk);
    io = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == IDMP_OFS_MODE && v[3:2] == 2'b11)
      v[3:2] = IDMP_TT_VERIFY;
    access(1'b0, a, v);
  endtask

  task automatic rd(input logic [7:0] a);
    access(1'b1, a, 8'h00);
  endtask
endmodule

// [dv/idmp_top_tb_top.sv]
`timescale 1ns/1ps
module idmp_top_tb_top
  import idmp_pkg::*;
;
  logic        clk;
  logic        reset;
  logic        ce;
  idmp_io_s    io;
  logic [7:0]  rdata;
  logic        rvalid;
  logic        mode_cnt_clr;
  logic        wide_access;
  logic [63:0] base_addr;
  logic [63:0] base_count;
  idmp_xfer_s  xfer;
  logic [3:0]  wide_tc_evt;
  logic [23:0] mem_addr;
  logic [1:0]  xfer_mode;
  logic [1:0]  xfer_type;
  logic [3:0]  byte_auto_mask_set;
  logic [3:0]  wide_mask;
  logic [3:0]  wide_tc_status;
  logic        byte_ptr;
  logic        wide_mclr;
  logic [7:0]  exp_q[$];
  int          bad_count;
  int          tests_run;
  int          cyc;
  logic [15:0] lfsr;
  logic [15:0] base;
  logic [3:0]  mset;
  logic        mclr_seen;
  logic [7:0]  pg[4];
  logic [7:0]  ofs[4];

  // Clock, 40 ns period
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  idmp_host_model host_u (
    .clk (clk),
    .io  (io)
  );

  idmp_top dut_u (
    .clk                (clk),
    .reset              (reset),
    .ce                 (ce),
    .io                 (io),
    .rdata              (rdata),
    .rvalid             (rvalid),
    .mode_cnt_clr       (mode_cnt_clr),
    .wide_access        (wide_access),
    .base_addr          (base_addr),
    .base_count         (base_count),
    .xfer               (xfer),
    .wide_tc_evt        (wide_tc_evt),
    .mem_addr           (mem_addr),
    .xfer_mode          (xfer_mode),
    .xfer_type          (xfer_type),
    .byte_auto_mask_set (byte_auto_mask_set),
    .wide_mask          (wide_mask),
    .wide_tc_status     (wide_tc_status),
    .byte_ptr           (byte_ptr),
    .wide_mclr          (wide_mclr)
  );

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction

  task automatic fail(input string msg);
    $display("MISMATCH at %0t: %s", $time, msg);
    bad_count++;
  endtask

  task automatic check(input logic [23:0] got, input logic [23:0] exp, input string msg);
    tests_run++;
    if (got !== exp)
      fail(msg);
  endtask

  // Note the expected byte before the read goes out
  task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host_u.rd(a);
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Start or step channel on the current chan, then let the address settle
  task automatic xstep(input logic st);
    @(negedge clk);
    xfer.start = st;
    xfer.step = !st;
    @(negedge clk);
    xfer.start = 1'b0;
    xfer.step = 1'b0;
    tick(2);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Read answers matched against the oldest note
  always @(negedge clk)
  begin
    if (wide_mclr === 1'b1)
      mclr_seen = 1'b1;
    mset = mset | byte_auto_mask_set;
    if (rvalid === 1'b1)
    begin
      tests_run++;
      if (exp_q.size() == 0)
        fail("read answer without request");
      else
      begin
        if (rdata !== exp_q[0])
          fail("read data differs");
        void'(exp_q.pop_front());
      end
    end
  end

  // Hang guard, far above the 140 or so cycles needed
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      fail("timeout");
      tally_and_finish();
    end
  end

  initial
  begin
    lfsr = 16'd38137;
    reset = 1'b1;
    ce = 1'b1;
    mode_cnt_clr = 1'b0;
    wide_access = 1'b0;
    base_addr = '0;
    base_count = '0;
    xfer = '0;
    wide_tc_evt = 4'h0;
    mset = 4'h0;
    mclr_seen = 1'b0;
    ofs = '{IDMP_OFS_PAGE_CH0, IDMP_OFS_PAGE_CH1, IDMP_OFS_PAGE_CH2, IDMP_OFS_PAGE_CH3};
    tick(3);
    reset = 1'b0;
    for (int i = 0; i < 4; i++)
      rd_exp(ofs[i], 8'h00);
    rd_exp(IDMP_OFS_MASK_ALL, 8'h00);
    check(24'(xfer_mode), 24'(IDMP_XM_DEMAND), "reset mode");
    tick(1);
    mode_cnt_clr = 1'b1;
    tick(1);
    mode_cnt_clr = 1'b0;
    for (int i = 0; i < 4; i++)
      rd_exp(IDMP_OFS_MODE, 8'h03);
    $display("test reset done");

    // Page registers, unmapped and write-only reads
    for (int i = 0; i < 4; i++)
    begin
      pg[i] = rnd();
      host_u.wr(ofs[i], pg[i]);
    end
    for (int i = 0; i < 4; i++)
      rd_exp(ofs[i], pg[i]);
    rd_exp(8'h50, 8'h00);
    rd_exp(IDMP_OFS_MCLR, 8'h00);
    $display("test pages done");

    // Distinct mode per channel: every mode and type
    for (int i = 0; i < 4; i++)
      host_u.wr(IDMP_OFS_MODE, {i[1:0], i[0], 1'b0, 2'(i % 3), i[1:0]});
    tick(1);
    mode_cnt_clr = 1'b1;
    tick(1);
    mode_cnt_clr = 1'b0;
    for (int i = 0; i < 4; i++)
      rd_exp(IDMP_OFS_MODE, {i[1:0], i[0], 1'b0, 2'(i % 3), 2'b11});
    for (int i = 0; i < 4; i++)
    begin
      xfer.chan = 2'(i);
      tick(2);
      check(24'(xfer_mode), 24'(i[1:0]), "channel mode");
      check(24'(xfer_type), 24'(i % 3), "channel type");
    end
    $display("test modes done");

    // Word controller mask and clear commands
    host_u.wr(IDMP_OFS_MASK_ALL, 8'hff);
    rd_exp(IDMP_OFS_MASK_ALL, 8'h0f);
    check(24'(wide_mask), 24'h00000f, "mask all");
    host_u.wr(IDMP_OFS_UNMASK, rnd());
    tick(1);
    check(24'(wide_mask), 24'h000000, "unmask all");
    host_u.wr(IDMP_OFS_MASK_ALL, 8'h05);
    wide_tc_evt = 4'ha;
    tick(1);
    wide_tc_evt = 4'h0;
    tick(1);
    check(24'(wide_tc_status), 24'h00000a, "tc status set");
    host_u.wr(IDMP_OFS_MCLR, rnd());
    tick(2);
    check(24'(wide_mask), 24'h000000, "master clear mask");
    check(24'(mclr_seen), 24'h000001, "master clear pulse");
    check(24'(wide_tc_status), 24'h000000, "master clear tc");
    $display("test mask done");

    // Byte pointer toggles per access, any clear write zeroes it
    for (int i = 0; i < 3; i++)
    begin
      wide_access = 1'b1;
      tick(1);
      wide_access = 1'b0;
      tick(1);
      check(24'(byte_ptr), 24'(!i[0]), "byte pointer toggle");
    end
    host_u.wr(IDMP_OFS_BPTR_CLR, rnd());
    tick(1);
    check(24'(byte_ptr), 24'h000000, "byte pointer clear");
    // Enable low freezes the pointer even with an access pending
    ce = 1'b0;
    wide_access = 1'b1;
    tick(1);
    wide_access = 1'b0;
    ce = 1'b1;
    tick(1);
    check(24'(byte_ptr), 24'h000000, "byte pointer frozen");
    $display("test pointer done");

    // Channel 2 transfer: count 1 gives two steps, plain then autoinit with decrement
    base = {rnd(), rnd()};
    base_addr[32+:16] = base;
    base_count[32+:16] = 16'h0001;
    xfer.chan = 2'd2;
    for (int a = 0; a < 2; a++)
    begin
      host_u.wr(IDMP_OFS_MODE, (a != 0) ? 8'hb6 : 8'h86);
      xstep(1'b1);
      check(mem_addr, {pg[2], base}, "start address");
      mset = 4'h0;
      xstep(1'b0);
      check(mem_addr, {pg[2], (a != 0) ? base - 16'h0001 : base + 16'h0001}, "step address");
      xstep(1'b0);
      check(mem_addr, {pg[2], (a != 0) ? base : base + 16'h0002}, "tc address");
      check(24'(mset), (a != 0) ? 24'h000000 : 24'h000004, "tc mask request");
    end
    $display("test transfer done");

    // Processor reset in mid-run wipes the mask, the pages and the modes
    host_u.wr(IDMP_OFS_MASK_ALL, 8'h0a);
    check(24'(wide_mask), 24'h00000a, "mask before reset");
    reset = 1'b1;
    tick(2);
    reset = 1'b0;
    check(24'(wide_mask), 24'h000000, "mask after reset");
    check(24'(xfer_mode), 24'(IDMP_XM_DEMAND), "mode after reset");
    for (int i = 0; i < 4; i++)
      rd_exp(ofs[i], 8'h00);
    // Let the last answer reach the checker before the verdict
    tick(2);
    if (exp_q.size() != 0)
      fail("read answers missing");
    $display("test midrun reset done");
    tally_and_finish();
  end
endmodule
